// File: logic/fotc_core.sv
// fotc_core: offset table storage, command handling and frequency correction
`timescale 1ns/1ps
module fotc_core
	import fotc_pkg::*;
(
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    srst,
	// decoded commands
	input  wire logic                    cmd_valid,
	output logic                         cmd_ready,
	input  wire fotc_cmd_t               cmd,
	// answers
	output logic                         rsp_valid,
	input  wire logic                    rsp_ready,
	output fotc_rsp_t                    rsp,
	// errors
	output logic                         err_valid,
	output logic signed [15:0]           err_code,
	// correction path
	input  wire logic signed [OFS_W-1:0] sensor_corr,
	output logic signed [OFS_W-1:0]      applied_offset,
	output logic signed [OFS_W-1:0]      total_corr,
	output logic                         corr_enabled
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_RSP, ST_STREAM, ST_LOAD, ST_COMMIT, ST_SEARCH, ST_INTERP
	} fotc_state_t;

	typedef enum logic [1:0] {SK_FREQ, SK_GAIN, SK_CAT} fotc_strm_t;

	typedef struct packed {
		fotc_state_t             st;
		logic [IDX_W-1:0]        edit_idx;
		logic                    corr_has;
		logic [IDX_W-1:0]        corr_idx;
		logic                    corr_en;
		logic                    load_gain;
		logic [PT_W-1:0]         cnt;
		logic                    ovf;
		logic [PT_W-1:0]         pos;
		fotc_strm_t              sk;
		logic [FREQ_W-1:0]       meas_freq;
		logic signed [OFS_W-1:0] applied;
		logic signed [OFS_W-1:0] total;
		fotc_rsp_t               rsp;
		logic                    err_valid;
		logic signed [15:0]      err_code;
	} fotc_core_t;

	fotc_core_t s;
	fotc_core_t next_s;

	// table storage
	logic [FREQ_W-1:0]       freq_mem [NUM_TABLES][MAX_POINTS];
	logic signed [OFS_W-1:0] ofs_mem  [NUM_TABLES][MAX_POINTS];
	logic [FREQ_W-1:0]       stage    [MAX_POINTS];
	fotc_name_t              names    [NUM_TABLES];
	logic [PT_W-1:0]         fpts     [NUM_TABLES];
	logic [PT_W-1:0]         gpts     [NUM_TABLES];

	logic                    hit;
	logic [IDX_W-1:0]        hit_idx;
	logic [FREQ_W-1:0]       freq_hz;
	logic [2*FREQ_W-1:0]     freq_prod;
	logic [BYTE_W-1:0]       used;
	logic [PT_W-1:0]         npts;
	logic [PT_W-1:0]         sidx;
	logic [PT_W-1:0]         pidx;
	logic                    ip_start;
	logic                    ip_done;
	logic signed [OFS_W-1:0] ip_result;
	fotc_strm_t              bk;
	logic [PT_W-1:0]         bp;
	fotc_rsp_t               beat;
	logic                    stage_we;
	logic                    commit_we;
	logic                    commit_end;
	logic                    name_we;

	function automatic logic name_ok(fotc_name_t nm);
		logic       ok;
		logic       ended;
		logic [7:0] c;
		ok = nm[NAME_CHARS*8-1 -: 8] != 8'h00;
		ended = 1'b0;
		for (int i = NAME_CHARS - 1; i >= 0; i--)
		begin
			c = nm[i*8 +: 8];
			if (c == 8'h00)
				ended = 1'b1;
			else if (ended || !((c >= 8'h41 && c <= 8'h5A) || (c >= 8'h61 && c <= 8'h7A)
					|| (c >= 8'h30 && c <= 8'h39) || c == 8'h5F))
				ok = 1'b0;
		end
		return ok;
	endfunction

	function automatic logic [BYTE_W-1:0] tsize(logic [PT_W-1:0] f, logic [PT_W-1:0] g);
		return TABLE_HDR_BYTES + BYTE_W'(({1'b0, f} + {1'b0, g}) * VALUE_BYTES);
	endfunction

	always_comb
	begin
		hit = 1'b0;
		hit_idx = '0;
		used = '0;
		for (int t = 0; t < NUM_TABLES; t++)
		begin
			if (names[t] == cmd.name && !hit)
			begin
				hit = 1'b1;
				hit_idx = IDX_W'(t);
			end
			used = used + tsize(fpts[t], gpts[t]);
		end
	end

	// unit multiplier applied before storage, so readback is in hertz
	always_comb
	begin
		unique case (cmd.unit)
			UNIT_KHZ: freq_prod = {{FREQ_W{1'b0}}, FREQ_W'(cmd.value)} * MULT_KHZ;
			UNIT_MHZ: freq_prod = {{FREQ_W{1'b0}}, FREQ_W'(cmd.value)} * MULT_MHZ;
			UNIT_GHZ: freq_prod = {{FREQ_W{1'b0}}, FREQ_W'(cmd.value)} * MULT_GHZ;
			default:  freq_prod = {{FREQ_W{1'b0}}, FREQ_W'(cmd.value)} * MULT_HZ;
		endcase
		freq_hz = freq_prod[FREQ_W-1:0];
	end

	assign npts = (fpts[s.corr_idx] < gpts[s.corr_idx]) ? fpts[s.corr_idx] : gpts[s.corr_idx];
	assign sidx = (s.pos >= PT_W'(MAX_POINTS)) ? PT_W'(MAX_POINTS - 1) : s.pos;
	assign pidx = (s.pos == '0) ? '0 : s.pos - PT_W'(1);

	// next answer beat of a multi-beat stream
	always_comb
	begin
		bk = (s.st == ST_STREAM) ? s.sk : (cmd.op == OP_FREQ_Q) ? SK_FREQ
			: (cmd.op == OP_GAIN_Q) ? SK_GAIN : SK_CAT;
		bp = (s.st == ST_STREAM) ? s.pos + PT_W'(1) : '0;
		beat = '0;
		unique case (bk)
			SK_FREQ:
			begin
				beat.num = FREQ_W'(freq_mem[s.edit_idx][bp]);
				beat.last = bp == fpts[s.edit_idx] - PT_W'(1);
				beat.kind = (fpts[s.edit_idx] == '0) ? RSP_EMPTY : RSP_NUM;
				beat.last = beat.last || fpts[s.edit_idx] == '0;
			end
			SK_GAIN:
			begin
				beat.num = FREQ_W'(ofs_mem[s.edit_idx][bp]);
				beat.last = bp == gpts[s.edit_idx] - PT_W'(1) || gpts[s.edit_idx] == '0;
				beat.kind = (gpts[s.edit_idx] == '0) ? RSP_EMPTY : RSP_NUM;
			end
			default:
			begin
				beat.last = bp == PT_W'(CAT_LAST);
				if (bp == '0)
					beat.num = FREQ_W'(used);
				else if (bp == PT_W'(1))
					beat.num = FREQ_W'(STORE_BYTES - used);
				else
				begin
					beat.kind = RSP_ENTRY;
					beat.name = names[IDX_W'(bp - PT_W'(2))];
					beat.size = tsize(fpts[IDX_W'(bp - PT_W'(2))], gpts[IDX_W'(bp - PT_W'(2))]);
				end
			end
		endcase
	end

	always_comb
	begin
		next_s = s;
		next_s.err_valid = 1'b0;
		next_s.total = sensor_corr + s.applied;
		ip_start = 1'b0;
		stage_we = 1'b0;
		commit_we = 1'b0;
		commit_end = 1'b0;
		name_we = 1'b0;
		unique case (s.st)
			ST_IDLE:
			begin
				if (cmd_valid)
				begin
					next_s.rsp = '0;
					next_s.rsp.last = 1'b1;
					next_s.err_code = ERR_PARAM;
					unique case (cmd.op)
						OP_EDIT_SEL, OP_CORR_SEL:
						begin
							if (hit && cmd.op == OP_EDIT_SEL)
								next_s.edit_idx = hit_idx;
							else if (hit)
							begin
								next_s.corr_has = 1'b1;
								next_s.corr_idx = hit_idx;
								next_s.pos = '0;
								next_s.st = ST_SEARCH;
							end
							else
								next_s.err_valid = 1'b1;
						end
						OP_EDIT_SEL_Q, OP_CORR_SEL_Q:
						begin
							next_s.rsp.kind = RSP_NAME;
							next_s.rsp.name = names[s.edit_idx];
							if (cmd.op == OP_CORR_SEL_Q)
							begin
								next_s.rsp.name = names[s.corr_idx];
								next_s.rsp.kind = s.corr_has ? RSP_NAME : RSP_EMPTY;
							end
							next_s.st = ST_RSP;
						end
						OP_FREQ_PTS_Q, OP_GAIN_PTS_Q:
						begin
							next_s.rsp.num = FREQ_W'((cmd.op == OP_FREQ_PTS_Q) ?
								fpts[s.edit_idx] : gpts[s.edit_idx]);
							next_s.st = ST_RSP;
						end
						OP_OFFSET_Q:
						begin
							next_s.rsp.num = FREQ_W'(s.applied);
							next_s.st = ST_RSP;
						end
						OP_FREQ_Q, OP_GAIN_Q, OP_CATALOG_Q:
						begin
							next_s.rsp = beat;
							next_s.sk = bk;
							next_s.pos = '0;
							next_s.st = ST_STREAM;
						end
						OP_FREQ_BEGIN, OP_GAIN_BEGIN:
						begin
							next_s.load_gain = cmd.op == OP_GAIN_BEGIN;
							next_s.cnt = '0;
							next_s.ovf = 1'b0;
							next_s.st = ST_LOAD;
						end
						OP_RENAME:
						begin
							if (hit && name_ok(cmd.name2))
								name_we = 1'b1;
							else
								next_s.err_valid = 1'b1;
						end
						OP_CORR_STATE:
						begin
							if (cmd.value[0] && !s.corr_has)
							begin
								next_s.err_code = ERR_CONFLICT;
								next_s.err_valid = 1'b1;
							end
							else
							begin
								next_s.corr_en = cmd.value[0];
								next_s.pos = '0;
								next_s.st = ST_SEARCH;
							end
						end
						OP_SET_FREQ:
						begin
							if (cmd.unit == UNIT_PCT)
								next_s.err_valid = 1'b1;
							else
							begin
								next_s.meas_freq = freq_hz;
								next_s.pos = '0;
								next_s.st = ST_SEARCH;
							end
						end
						default:
							next_s.err_valid = cmd.op != OP_NOP;
					endcase
				end
			end
			ST_RSP:
			begin
				if (rsp_ready)
					next_s.st = ST_IDLE;
			end
			ST_STREAM:
			begin
				if (rsp_ready)
				begin
					next_s.rsp = beat;
					next_s.pos = bp;
					if (s.rsp.last)
						next_s.st = ST_IDLE;
				end
			end
			ST_LOAD:
			begin
				if (cmd_valid && cmd.op == OP_LIST_DATA)
				begin
					if (s.cnt == PT_W'(MAX_POINTS))
						next_s.ovf = 1'b1;
					else if (s.load_gain ? (cmd.unit != UNIT_NONE && cmd.unit != UNIT_PCT)
							: cmd.unit == UNIT_PCT)
					begin
						next_s.err_code = ERR_PARAM;
						next_s.err_valid = 1'b1;
						next_s.st = ST_IDLE;
					end
					else
					begin
						stage_we = 1'b1;
						next_s.cnt = s.cnt + PT_W'(1);
					end
				end
				else if (cmd_valid && cmd.op == OP_LIST_END && s.ovf)
				begin
					next_s.err_code = ERR_DATA_RANGE;
					next_s.err_valid = 1'b1;
					next_s.st = ST_IDLE;
				end
				else if (cmd_valid && cmd.op == OP_LIST_END)
				begin
					next_s.pos = '0;
					next_s.st = ST_COMMIT;
				end
				else if (cmd_valid)
				begin
					// any other command abandons the list, old data stays
					next_s.err_code = ERR_PARAM;
					next_s.err_valid = 1'b1;
					next_s.st = ST_IDLE;
				end
			end
			ST_COMMIT:
			begin
				commit_we = s.pos < s.cnt;
				next_s.pos = s.pos + PT_W'(1);
				if (s.pos >= s.cnt || s.pos == PT_W'(MAX_POINTS - 1))
				begin
					commit_end = 1'b1;
					next_s.pos = '0;
					next_s.st = ST_SEARCH;
				end
			end
			ST_SEARCH:
			begin
				next_s.st = ST_IDLE;
				if (!s.corr_en || !s.corr_has || npts == '0)
					next_s.applied = '0;
				else if (s.pos < npts && freq_mem[s.corr_idx][sidx] < s.meas_freq)
				begin
					next_s.pos = s.pos + PT_W'(1);
					next_s.st = ST_SEARCH;
				end
				else if (s.pos == '0 || (s.pos < npts
						&& freq_mem[s.corr_idx][sidx] == s.meas_freq))
					next_s.applied = ofs_mem[s.corr_idx][sidx];
				else if (s.pos == npts)
					next_s.applied = ofs_mem[s.corr_idx][pidx];
				else
				begin
					ip_start = 1'b1;
					next_s.st = ST_INTERP;
				end
			end
			ST_INTERP:
			begin
				if (ip_done)
				begin
					next_s.applied = ip_result;
					next_s.st = ST_IDLE;
				end
			end
			default:
				next_s.st = ST_IDLE;
		endcase
	end

	fotc_interp u_interp (
		.clk     (clk),
		.srst    (srst),
		.start   (ip_start),
		.ofs_lo  (ofs_mem[s.corr_idx][pidx]),
		.ofs_hi  (ofs_mem[s.corr_idx][sidx]),
		.freq_lo (freq_mem[s.corr_idx][pidx]),
		.freq_hi (freq_mem[s.corr_idx][sidx]),
		.freq_x  (s.meas_freq),
		.done    (ip_done),
		.result  (ip_result)
	);

	always_ff @(posedge clk)
	begin
		if (srst)
			s <= '0;
		else
			s <= next_s;
	end

	// storage: fixed set of tables, nothing is ever created
	always_ff @(posedge clk)
	begin
		if (stage_we)
			stage[s.cnt] <= s.load_gain ? FREQ_W'(signed'(cmd.value)) : freq_hz;
		if (commit_we && s.load_gain)
			ofs_mem[s.edit_idx][sidx] <= stage[sidx][OFS_W-1:0];
		if (commit_we && !s.load_gain)
			freq_mem[s.edit_idx][sidx] <= stage[sidx];
		if (srst)
		begin
			for (int t = 0; t < NUM_TABLES; t++)
			begin
				names[t] <= {NAME_PREFIX, DIGIT_ZERO + 8'(t), 32'h0000_0000};
				fpts[t] <= '0;
				gpts[t] <= '0;
			end
		end
		else
		begin
			if (name_we)
				names[hit_idx] <= cmd.name2;
			if (commit_end && s.load_gain)
				gpts[s.edit_idx] <= s.cnt;
			if (commit_end && !s.load_gain)
				fpts[s.edit_idx] <= s.cnt;
		end
	end

	assign cmd_ready = s.st == ST_IDLE || s.st == ST_LOAD;
	assign rsp_valid = s.st == ST_RSP || s.st == ST_STREAM;
	assign rsp = s.rsp;
	assign err_valid = s.err_valid;
	assign err_code = s.err_code;
	assign applied_offset = s.applied;
	assign total_corr = s.total;
	assign corr_enabled = s.corr_en;
endmodule

// File: inc/fotc_pkg.sv
// fotc_pkg: shared constants and types of the frequency offset table correction unit
package fotc_pkg;
	localparam int NUM_TABLES = 10;
	localparam int MAX_POINTS = 80;
	localparam int NAME_CHARS = 12;
	localparam int FREQ_W     = 40;
	localparam int OFS_W      = 32;
	localparam int VAL_W      = 32;
	localparam int IDX_W      = 4;
	localparam int PT_W       = 7;
	localparam int BYTE_W     = 16;
	localparam int CAT_LAST   = NUM_TABLES + 1;

	// storage accounting for the catalog answer
	localparam logic [BYTE_W-1:0] TABLE_HDR_BYTES = 16'h0014;
	localparam logic [BYTE_W-1:0] VALUE_BYTES     = 16'h0004;
	localparam logic [BYTE_W-1:0] STORE_BYTES     = 16'h2000;

	// frequency multipliers, hertz per unit
	localparam logic [FREQ_W-1:0] MULT_HZ  = 40'h00_0000_0001;
	localparam logic [FREQ_W-1:0] MULT_KHZ = 40'h00_0000_03E8;
	localparam logic [FREQ_W-1:0] MULT_MHZ = 40'h00_000F_4240;
	localparam logic [FREQ_W-1:0] MULT_GHZ = 40'h00_3B9A_CA00;

	// reset names are the prefix followed by one digit
	localparam logic [55:0] NAME_PREFIX = 56'h4F_4646_5345_545F;
	localparam logic [7:0]  DIGIT_ZERO  = 8'h30;

	localparam logic signed [15:0] ERR_CONFLICT   = 16'hFF23;
	localparam logic signed [15:0] ERR_DATA_RANGE = 16'hFF22;
	localparam logic signed [15:0] ERR_PARAM      = 16'hFF20;

	typedef logic [NAME_CHARS*8-1:0] fotc_name_t;

	typedef enum logic [4:0] {
		OP_NOP, OP_EDIT_SEL, OP_EDIT_SEL_Q, OP_FREQ_BEGIN, OP_GAIN_BEGIN, OP_LIST_DATA,
		OP_LIST_END, OP_FREQ_PTS_Q, OP_GAIN_PTS_Q, OP_FREQ_Q, OP_GAIN_Q, OP_RENAME,
		OP_CORR_SEL, OP_CORR_SEL_Q, OP_CORR_STATE, OP_CATALOG_Q, OP_SET_FREQ, OP_OFFSET_Q
	} fotc_op_t;

	typedef enum logic [2:0] {
		UNIT_NONE, UNIT_HZ, UNIT_KHZ, UNIT_MHZ, UNIT_GHZ, UNIT_PCT
	} fotc_unit_t;

	typedef enum logic [1:0] {RSP_NUM, RSP_NAME, RSP_ENTRY, RSP_EMPTY} fotc_rsp_kind_t;

	typedef struct packed {
		fotc_op_t         op;
		fotc_name_t       name;
		fotc_name_t       name2;
		logic [VAL_W-1:0] value;
		fotc_unit_t       unit;
	} fotc_cmd_t;

	typedef struct packed {
		fotc_rsp_kind_t           kind;
		logic                     last;
		logic signed [FREQ_W-1:0] num;
		fotc_name_t               name;
		logic [BYTE_W-1:0]        size;
	} fotc_rsp_t;
endpackage

// File: logic/fotc_interp.sv
// fotc_interp: linear interpolation of an offset between two table points
`timescale 1ns/1ps
module fotc_interp
	import fotc_pkg::*;
#(
	parameter int OW = OFS_W,
	parameter int FW = FREQ_W
)
(
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 srst,
	// operands, taken on start
	input  wire logic                 start,
	input  wire logic signed [OW-1:0] ofs_lo,
	input  wire logic signed [OW-1:0] ofs_hi,
	input  wire logic [FW-1:0]        freq_lo,
	input  wire logic [FW-1:0]        freq_hi,
	input  wire logic [FW-1:0]        freq_x,
	// result
	output logic                      done,
	output logic signed [OW-1:0]      result
);
	localparam int PW = OW + 1 + FW;

	if (OW < 2 || FW < 2)
	begin : g_bad_width
		$error("fotc_interp: widths too small");
	end

	typedef struct packed {
		logic                 busy;
		logic [7:0]           cnt;
		logic [FW:0]          rem;
		logic [PW-1:0]        quo;
		logic [FW-1:0]        span;
		logic                 neg;
		logic signed [OW-1:0] base;
		logic                 done;
		logic signed [OW-1:0] result;
	} fotc_div_t;

	fotc_div_t s;
	fotc_div_t next_s;

	logic signed [OW:0] diff;
	logic [OW:0]        mag;
	logic [FW:0]        rem_sh;
	logic [PW-1:0]      prod;
	logic signed [OW:0] q_s;

	always_comb
	begin
		next_s = s;
		next_s.done = 1'b0;
		diff = {ofs_hi[OW-1], ofs_hi} - {ofs_lo[OW-1], ofs_lo};
		mag = diff[OW] ? (OW+1)'(-diff) : diff;
		prod = PW'(mag) * PW'(freq_x - freq_lo);
		rem_sh = {s.rem[FW-1:0], s.quo[PW-1]};
		q_s = s.neg ? (OW+1)'(-s.quo[OW:0]) : s.quo[OW:0];
		if (start)
		begin
			next_s.busy = 1'b1;
			next_s.cnt = 8'(PW);
			next_s.rem = '0;
			next_s.quo = prod;
			next_s.span = freq_hi - freq_lo;
			next_s.neg = diff[OW];
			next_s.base = ofs_lo;
		end
		else if (s.busy && s.cnt != 8'h00)
		begin
			// restoring division, one quotient bit a cycle
			if (rem_sh >= {1'b0, s.span})
			begin
				next_s.rem = rem_sh - {1'b0, s.span};
				next_s.quo = {s.quo[PW-2:0], 1'b1};
			end
			else
			begin
				next_s.rem = rem_sh;
				next_s.quo = {s.quo[PW-2:0], 1'b0};
			end
			next_s.cnt = s.cnt - 8'h01;
		end
		else if (s.busy)
		begin
			// quotient never exceeds the offset step, so it fits
			next_s.busy = 1'b0;
			next_s.done = 1'b1;
			next_s.result = s.base + q_s[OW-1:0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			s <= '0;
		else
			s <= next_s;
	end

	assign done = s.done;
	assign result = s.result;
endmodule

// File: verification/fotc_core_sva.sv
// fotc_core_sva: port level assertions for the offset table correction core
`timescale 1ns/1ps
module fotc_core_sva
	import fotc_pkg::*;
(
	// clock and reset
	input wire logic                    clk,
	input wire logic                    srst,
	// commands and answers
	input wire logic                    cmd_valid,
	input wire logic                    cmd_ready,
	input wire fotc_cmd_t               cmd,
	input wire logic                    rsp_valid,
	input wire logic                    rsp_ready,
	input wire fotc_rsp_t               rsp,
	// errors and correction path
	input wire logic                    err_valid,
	input wire logic signed [15:0]      err_code,
	input wire logic signed [OFS_W-1:0] sensor_corr,
	input wire logic signed [OFS_W-1:0] applied_offset,
	input wire logic signed [OFS_W-1:0] total_corr,
	input wire logic                    corr_enabled
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	logic taken;
	assign taken = cmd_valid && cmd_ready;
	sequence s_take(fotc_op_t o);
		taken && cmd.op == o;
	endsequence
	sequence s_num_beat;
		rsp_valid && rsp.kind == RSP_NUM;
	endsequence
	a_total_sum: assert property (!$past(srst) |->
		total_corr == $past(sensor_corr) + $past(applied_offset)) else $error("total mismatch");
	a_off_zero: assert property (!corr_enabled && !$past(corr_enabled) |-> applied_offset == '0)
		else $error("offset while off");
	a_conflict_off: assert property (err_valid && err_code == ERR_CONFLICT |-> !corr_enabled)
		else $error("enabled after conflict");
	a_err_cause: assert property (err_valid |-> $past(taken)) else $error("error without command");
	a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
		else $error("answer dropped");
	a_offset_answer: assert property (s_take(OP_OFFSET_Q) |=> s_num_beat ##0 (rsp.last &&
		rsp.num == {{8{$past(applied_offset[31])}}, $past(applied_offset)})) else $error("bad offset");
	a_sel_name: assert property (s_take(OP_EDIT_SEL_Q) |=>
		rsp_valid && rsp.kind == RSP_NAME && rsp.last) else $error("bad name answer");
	a_corr_name: assert property (s_take(OP_CORR_SEL_Q) |=> rsp_valid && rsp.last &&
		(rsp.kind == RSP_NAME || (rsp.kind == RSP_EMPTY && !corr_enabled)))
		else $error("bad correction name answer");
	a_pts_range: assert property (s_take(OP_FREQ_PTS_Q) |=> s_num_beat ##0
		(rsp.num >= 0 && rsp.num <= MAX_POINTS)) else $error("bad point count");
	a_catalog_head: assert property (s_take(OP_CATALOG_Q) |=> s_num_beat ##0 !rsp.last)
		else $error("bad catalog head");
	a_freq_settle: assert property (s_take(OP_SET_FREQ) |-> ##[1:300] cmd_ready)
		else $error("derivation hung");
	a_offset_stands: assert property (!$past(srst) && $past(cmd_ready) && cmd_ready |->
		$stable(applied_offset)) else $error("offset moved while idle");
endmodule
bind fotc_core fotc_core_sva u_sva (.clk(clk), .srst(srst), .cmd_valid(cmd_valid),
	.cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
	.rsp(rsp), .err_valid(err_valid), .err_code(err_code), .sensor_corr(sensor_corr),
	.applied_offset(applied_offset), .total_corr(total_corr), .corr_enabled(corr_enabled));

// File: verification/fotc_host.sv
// fotc_host: host issuing configuration commands and accepting answers
`timescale 1ns/1ps
module fotc_host
	import fotc_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// command side
	output fotc_cmd_t cmd,
	output logic      cmd_valid,
	input  wire logic cmd_ready,
	// answer side
	input  wire logic rsp_valid,
	output logic      rsp_ready
);
	logic [1:0] pace = 2'h0;
	initial
	begin
		cmd_valid = 1'b0;
		cmd = '0;
		rsp_ready = 1'b0;
	end
	// one stall in four cycles keeps the answer hold path busy
	always @(posedge clk)
	begin
		pace <= srst ? 2'h0 : pace + 2'h1;
		rsp_ready <= pace != 2'h3;
	end
	task automatic send(input fotc_op_t op, input fotc_name_t n, input logic [VAL_W-1:0] v,
		input fotc_unit_t u, input fotc_name_t n2 = '0);
		int w;
		w = 0;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd <= '{op, n, n2, v, u};
		@(posedge clk);
		while (!cmd_ready && w < 400)
		begin
			w++;
			@(posedge clk);
		end
		cmd_valid <= 1'b0;
		// released bus shows the inverse so stale fields never look valid
		cmd <= ~cmd;
	endtask
	// whole lists only, never a patch of one entry
	task automatic load(input fotc_op_t op, input logic [VAL_W-1:0] v[$], input fotc_unit_t u[$]);
		send(op, '0, '0, UNIT_NONE);
		foreach (v[i]) send(OP_LIST_DATA, '0, v[i], u[i]);
		send(OP_LIST_END, '0, '0, UNIT_NONE);
	endtask
endmodule

// File: verification/tb.sv
// tb: self checking bench for the offset table correction core
`timescale 1ns/1ps
module tb
	import fotc_pkg::*;
;
	logic clk, srst, cmd_valid, cmd_ready, rsp_valid, rsp_ready, err_valid, corr_enabled;
	fotc_cmd_t               cmd;
	fotc_rsp_t               rsp;
	logic signed [15:0]      err_code;
	logic signed [OFS_W-1:0] sensor_corr, applied_offset, total_corr;
	fotc_rsp_t               exp_rsp[$];
	logic signed [15:0]      exp_err[$];
	int                      miscompares, tests_run;

	fotc_core dut (.clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd(cmd), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp),
		.err_valid(err_valid), .err_code(err_code), .sensor_corr(sensor_corr),
		.applied_offset(applied_offset), .total_corr(total_corr), .corr_enabled(corr_enabled));
	fotc_host host (.clk(clk), .srst(srst), .cmd(cmd), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) sensor_corr <= $urandom;

	task automatic check(input string what, input logic [95:0] e, input logic [95:0] g);
		tests_run++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %s expected %0h seen %0h", what, e, g);
		end
	endtask
	task automatic end_sim();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	function automatic fotc_name_t nm(input string s);
		fotc_name_t r;
		r = '0;
		for (int i = 0; i < s.len(); i++) r[NAME_CHARS*8-1-8*i -: 8] = s[i];
		return r;
	endfunction
	task automatic ex_num(input logic signed [FREQ_W-1:0] n, input logic l = 1'b1);
		exp_rsp.push_back('{RSP_NUM, l, n, '0, '0});
	endtask
	task automatic ex_name(input fotc_rsp_kind_t k, input fotc_name_t n, input logic l,
		input logic [BYTE_W-1:0] s);
		exp_rsp.push_back('{k, l, '0, n, s});
	endtask
	task automatic ask(input fotc_op_t op, input logic signed [FREQ_W-1:0] n);
		ex_num(n);
		host.send(op, '0, '0, UNIT_NONE);
	endtask
	task automatic askn(input fotc_op_t op, input fotc_name_t n);
		ex_name(RSP_NAME, n, 1'b1, '0);
		host.send(op, '0, '0, UNIT_NONE);
	endtask
	task automatic try_freq(input logic [31:0] v, input fotc_unit_t u, input int e);
		host.send(OP_SET_FREQ, '0, v, u);
		ask(OP_OFFSET_Q, e);
	endtask

	// answers and errors are matched in arrival order
	always @(posedge clk)
	begin
		fotc_rsp_t e;
		if (!srst && rsp_valid && rsp_ready)
		begin
			e = exp_rsp.size() != 0 ? exp_rsp.pop_front() : ~rsp;
			check("rsp kind", e.kind, rsp.kind);
			check("rsp last", e.last, rsp.last);
			if (e.kind == RSP_NUM)
				check("rsp num", e.num, rsp.num);
			else
				check("rsp name", e.name, rsp.name);
			if (e.kind == RSP_ENTRY)
				check("rsp size", e.size, rsp.size);
		end
		if (!srst && err_valid)
			check("err code", exp_err.size() != 0 ? exp_err.pop_front() : ~err_code, err_code);
	end

	initial
	begin
		repeat (30000) @(posedge clk);
		miscompares++;
		end_sim();
	end

	initial
	begin
		logic [31:0] f;
		logic [VAL_W-1:0] fv[$], gv[$];
		fotc_unit_t fu[$], gu[$];
		logic signed [FREQ_W-1:0] fhz[$];
		miscompares = 0;
		tests_run = 0;
		srst = 1'b1;
		void'($urandom(32'ha980));
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		askn(OP_EDIT_SEL_Q, nm("OFFSET_0"));
		ex_num(NUM_TABLES * TABLE_HDR_BYTES, 1'b0);
		ex_num(STORE_BYTES - NUM_TABLES * TABLE_HDR_BYTES, 1'b0);
		for (int i = 0; i < NUM_TABLES; i++)
			ex_name(RSP_ENTRY, {NAME_PREFIX, DIGIT_ZERO + 8'(i), 32'h0000_0000}, i == NUM_TABLES - 1,
				TABLE_HDR_BYTES);
		host.send(OP_CATALOG_Q, '0, '0, UNIT_NONE);
		exp_err.push_back(ERR_CONFLICT);
		host.send(OP_CORR_STATE, '0, 32'h0000_0001, UNIT_NONE);
		repeat (2) @(posedge clk);
		check("corr on", 1'b0, corr_enabled);
		exp_err.push_back(ERR_PARAM);
		host.send(OP_EDIT_SEL, nm("OFFSET 3"), '0, UNIT_NONE);
		exp_err.push_back(ERR_PARAM);
		host.send(OP_EDIT_SEL, nm("NEW_TABLE"), '0, UNIT_NONE);
		askn(OP_EDIT_SEL_Q, nm("OFFSET_0"));
		host.send(OP_EDIT_SEL, nm("OFFSET_3"), '0, UNIT_NONE);
		fv = {32'h0000_0001, 32'h0000_0BB8, 32'h004C_4B40, 32'h006A_CFC0, 32'h0000_0001};
		fu = {UNIT_MHZ, UNIT_KHZ, UNIT_NONE, UNIT_HZ, UNIT_GHZ};
		fhz = {MULT_MHZ, 3 * MULT_MHZ, 5 * MULT_MHZ, 7 * MULT_MHZ, MULT_GHZ};
		gv = {32'h0000_03E8, 32'h0000_0BB8, 32'hFFFF_FC18, 32'h0000_07D0, 32'h0000_0FA0};
		gu = {UNIT_PCT, UNIT_NONE, UNIT_PCT, UNIT_NONE, UNIT_PCT};
		host.load(OP_FREQ_BEGIN, fv, fu);
		host.load(OP_GAIN_BEGIN, gv, gu);
		ask(OP_FREQ_PTS_Q, 5);
		ask(OP_GAIN_PTS_Q, 5);
		foreach (fhz[i]) ex_num(fhz[i], i == 4);
		host.send(OP_FREQ_Q, '0, '0, UNIT_NONE);
		foreach (gv[i]) ex_num(signed'(gv[i]), i == 4);
		host.send(OP_GAIN_Q, '0, '0, UNIT_NONE);
		// one point past capacity must leave the stored list intact
		exp_err.push_back(ERR_DATA_RANGE);
		host.send(OP_GAIN_BEGIN, '0, '0, UNIT_NONE);
		repeat (MAX_POINTS + 1) host.send(OP_LIST_DATA, '0, 32'h0000_0001, UNIT_NONE);
		host.send(OP_LIST_END, '0, '0, UNIT_NONE);
		// a frequency unit on an offset entry drops the load
		exp_err.push_back(ERR_PARAM);
		host.send(OP_GAIN_BEGIN, '0, '0, UNIT_NONE);
		host.send(OP_LIST_DATA, '0, 32'h0000_0001, UNIT_KHZ);
		ask(OP_GAIN_PTS_Q, 5);
		exp_err.push_back(ERR_PARAM);
		host.send(OP_RENAME, nm("OFFSET_3"), '0, UNIT_NONE, nm("bad name"));
		host.send(OP_RENAME, nm("OFFSET_3"), '0, UNIT_NONE, nm("my_tab_1"));
		askn(OP_EDIT_SEL_Q, nm("my_tab_1"));
		host.send(OP_CORR_SEL, nm("my_tab_1"), '0, UNIT_NONE);
		host.send(OP_EDIT_SEL, nm("OFFSET_0"), '0, UNIT_NONE);
		askn(OP_EDIT_SEL_Q, nm("OFFSET_0"));
		askn(OP_CORR_SEL_Q, nm("my_tab_1"));
		host.send(OP_CORR_STATE, '0, 32'h0000_0001, UNIT_NONE);
		exp_err.push_back(ERR_PARAM);
		host.send(OP_SET_FREQ, '0, 32'h0000_0064, UNIT_PCT);
		try_freq(32'h0000_0064, UNIT_HZ, 1000);
		try_freq(32'h0000_0002, UNIT_GHZ, 4000);
		try_freq(32'h0000_0BB8, UNIT_KHZ, 3000);
		try_freq(32'h0000_0002, UNIT_MHZ, 2000);
		try_freq(32'h0000_1770, UNIT_KHZ, 500);
		repeat (4)
		begin
			f = 32'h000F_4240 + $urandom % 32'h001E_8480;
			try_freq(f, UNIT_NONE, 1000 + (f - 32'h000F_4240) / 1000);
		end
		check("corr on", 1'b1, corr_enabled);
		host.send(OP_CORR_STATE, '0, '0, UNIT_NONE);
		ask(OP_OFFSET_Q, 0);
		for (int w = 0; w < 300 && (exp_rsp.size() != 0 || exp_err.size() != 0); w++)
			@(posedge clk);
		check("pending", '0, exp_rsp.size() + exp_err.size());
		end_sim();
	end
endmodule
